//--- src/mgmt_frame_pkg.sv
package mgmt_frame_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_HEAD = 3'b010,
    ST_TA = 3'b011,
    ST_DATA = 3'b100,
    ST_SKIP = 3'b101
  } frame_state_t;
endpackage

//--- src/mgmt_frame_regs.svh
`ifndef MGMT_FRAME_REGS_SVH
`define MGMT_FRAME_REGS_SVH

// Register indices
`define REG_PHY_CONTROL 5'h00
`define REG_PHY_STATUS 5'h01
`define REG_PHY_ID_HIGH 5'h02
`define REG_PHY_ID_LOW 5'h03
`define REG_AUTONEG_ADV 5'h04
`define REG_AUTONEG_PARTNER 5'h05
`define REG_PHY_CONFIG_ONE 5'h10
`define REG_PHY_CONFIG_TWO 5'h11
`define REG_EVENT_STATUS 5'h12
`define REG_EVENT_MASK 5'h13
`define REG_RESERVED_LAST 5'h14
`define REG_BURST_SELECT 5'h1f

// Field positions and reset values
`define CFG2_BURST_BIT 3
`define CTRL_RESET_VAL 16'h3400
`define STATUS_RESET_VAL 16'h7809
`define ADV_RESET_VAL 16'h01e1
`define CFG1_RESET_VAL 16'h0000
`define CFG2_RESET_VAL 16'h0000
`define MASK_RESET_VAL 16'h0000

// Frame timing in bit times; burst length in words
`define IDLE_ONES 6'd32
`define BURST_WORDS 5'd11
`define DATA_BITS 5'd16
`define HEAD_LAST_BIT 4'd11
`define TA_LAST_BIT 4'd1
`define DATA_LAST_BIT 4'd15

`endif

//--- src/phy_mgmt_serial_frame.sv
`timescale 1ns/1ps
`include "mgmt_frame_regs.svh"

module phy_mgmt_serial_frame
  import mgmt_frame_pkg::*;
#(
  parameter logic [15:0] ID_HIGH = 16'h1234, // Arbitrary value
  parameter logic [15:0] ID_LOW = 16'h5678 // Arbitrary value
) (
  // System
  input wire logic clk,
  input wire logic rst_n,
  // Management link
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  // Own address and live status inputs
  input wire logic [4:0] phy_select_field,
  input wire logic [15:0] status_in,
  input wire logic [15:0] partner_in,
  input wire logic [15:0] event_in,
  // Register contents
  output logic [15:0] control_out,
  output logic [15:0] config_one_out,
  output logic [15:0] config_two_out,
  output logic [15:0] mask_out
);

  logic mdc_s1_r;
  logic mdc_s2_r;
  logic mdc_s3_r;
  logic md_s1_r;
  logic md_s2_r;
  logic rise;
  frame_state_t state_r;
  logic [5:0] ones_r;
  logic [3:0] cnt_r;
  logic [12:0] head_r;
  logic is_read_r;
  logic match_r;
  logic burst_r;
  logic [4:0] reg_r;
  logic [15:0] shift_r;
  logic [15:0] ctrl_r;
  logic [15:0] cfg1_r;
  logic [15:0] cfg2_r;
  logic [15:0] mask_r;
  logic burst_en;
  logic in_frame;
  logic ta_second;

  // Two stages before use; third stage only for edge finding
  // Link clock must stay well below a quarter of clk
  always_ff @(posedge clk) begin
    mdc_s1_r <= mdc;
    mdc_s2_r <= mdc_s1_r;
    mdc_s3_r <= mdc_s2_r;
    md_s1_r <= mdio_in;
    md_s2_r <= md_s1_r;
  end
  assign rise = mdc_s2_r & ~mdc_s3_r;
  assign burst_en = cfg2_r[`CFG2_BURST_BIT];
  // Idle ones only count between frames, never inside one
  assign in_frame = state_r == ST_START || state_r == ST_HEAD || state_r == ST_TA || state_r == ST_DATA;
  // Second turnaround bit, the first one the device may drive
  assign ta_second = state_r == ST_TA && cnt_r == `TA_LAST_BIT;

  // Unimplemented and reserved addresses read back zero
  function automatic logic [15:0] read_reg(input logic [4:0] a);
    logic [15:0] v;
    v = 16'h0000;
    if (a == `REG_PHY_CONTROL) v = ctrl_r;
    else if (a == `REG_PHY_STATUS) v = status_in;
    else if (a == `REG_PHY_ID_HIGH) v = ID_HIGH;
    else if (a == `REG_PHY_ID_LOW) v = ID_LOW;
    else if (a == `REG_AUTONEG_ADV) v = `ADV_RESET_VAL;
    else if (a == `REG_AUTONEG_PARTNER) v = partner_in;
    else if (a == `REG_PHY_CONFIG_ONE) v = cfg1_r;
    else if (a == `REG_PHY_CONFIG_TWO) v = cfg2_r;
    else if (a == `REG_EVENT_STATUS) v = event_in;
    else if (a == `REG_EVENT_MASK) v = mask_r;
    return v;
  endfunction

  // Next implemented register in burst order 0..5 then 16..20
  function automatic logic [4:0] next_reg(input logic [4:0] a);
    return (a == `REG_AUTONEG_PARTNER) ? `REG_PHY_CONFIG_ONE : 5'(a + 5'd1);
  endfunction

  // Idle detector: count consecutive ones on each bit
  always_ff @(posedge clk) begin
    if (!rst_n) ones_r <= 6'd0;
    else if (rise) begin
      if (!md_s2_r || in_frame) ones_r <= 6'd0;
      else if (ones_r != `IDLE_ONES) ones_r <= ones_r + 6'd1;
    end
  end

  // A write lands at the rise of the last data bit
  logic write_now;
  logic last_bit;
  assign last_bit = (cnt_r == `DATA_LAST_BIT);
  assign write_now = rise && state_r == ST_DATA && last_bit && !is_read_r && match_r;

  // Frame walker; every step waits for a synced link clock rise
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      cnt_r <= 4'd0;
      head_r <= 13'd0;
      is_read_r <= 1'b0;
      match_r <= 1'b0;
      burst_r <= 1'b0;
      reg_r <= 5'd0;
      shift_r <= 16'h0000;
    end else if (rise) begin
      case (state_r)
        ST_IDLE: begin
          // Start zero only counts after a full idle run
          if (ones_r == `IDLE_ONES && !md_s2_r) state_r <= ST_START;
        end
        ST_START: begin
          // Anything but 0 then 1 waits for a fresh idle run
          if (md_s2_r) begin
            state_r <= ST_HEAD;
            cnt_r <= 4'd0;
          end else state_r <= ST_SKIP;
        end
        ST_HEAD: begin
          head_r <= {head_r[11:0], md_s2_r};
          cnt_r <= cnt_r + 4'd1;
          // Address sampled once per frame
          if (cnt_r == `HEAD_LAST_BIT) begin
            state_r <= ST_TA;
            cnt_r <= 4'd0;
            is_read_r <= head_r[10];
            match_r <= head_r[8:4] == phy_select_field;
            reg_r <= {head_r[3:0], md_s2_r};
            burst_r <= burst_en && {head_r[3:0], md_s2_r} == `REG_BURST_SELECT;
          end
        end
        ST_TA: begin
          cnt_r <= cnt_r + 4'd1;
          // First turnaround bit never driven; read word loads at the second
          if (cnt_r == `TA_LAST_BIT) begin
            state_r <= ST_DATA;
            cnt_r <= 4'd0;
            if (burst_r) reg_r <= `REG_PHY_CONTROL;
            shift_r <= read_reg(burst_r ? `REG_PHY_CONTROL : reg_r);
          end
        end
        ST_DATA: begin
          cnt_r <= cnt_r + 4'd1;
          if (is_read_r) shift_r <= {shift_r[14:0], 1'b0};
          else shift_r <= {shift_r[14:0], md_s2_r};
          if (last_bit) begin
            cnt_r <= 4'd0;
            // Burst writes land word by word; a cut burst keeps earlier words
            if (burst_r && reg_r != `REG_RESERVED_LAST) begin
              reg_r <= next_reg(reg_r);
              shift_r <= read_reg(next_reg(reg_r));
            end else state_r <= ST_SKIP;
          end
        end
        default: state_r <= ST_IDLE; // Wait for a fresh idle run
      endcase
    end
  end

  // Write path; station supplies the 1 0 turnaround itself
  logic [15:0] wdata;
  assign wdata = {shift_r[14:0], md_s2_r};
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_r <= `CTRL_RESET_VAL;
      cfg1_r <= `CFG1_RESET_VAL;
      cfg2_r <= `CFG2_RESET_VAL;
      mask_r <= `MASK_RESET_VAL;
    end else if (write_now) begin
      // Read-only and reserved addresses swallow writes
      if (reg_r == `REG_PHY_CONTROL) ctrl_r <= wdata;
      else if (reg_r == `REG_PHY_CONFIG_ONE) cfg1_r <= wdata;
      else if (reg_r == `REG_PHY_CONFIG_TWO) cfg2_r <= wdata;
      else if (reg_r == `REG_EVENT_MASK) mask_r <= wdata;
    end
  end

  // Drive only in second turnaround bit and data of a matched read
  always_ff @(posedge clk) begin
    if (!rst_n) mdio_oe <= 1'b0;
    else mdio_oe <= is_read_r && match_r && (ta_second || state_r == ST_DATA);
  end

  // Zero through the turnaround, then data MSB first
  always_ff @(posedge clk) begin
    if (!rst_n) mdio_out <= 1'b0;
    else mdio_out <= (state_r == ST_DATA) ? shift_r[15] : 1'b0;
  end

  // Register contents straight from their flip-flops
  assign control_out = ctrl_r;
  assign config_one_out = cfg1_r;
  assign config_two_out = cfg2_r;
  assign mask_out = mask_r;

endmodule

//--- tb/mgmt_chk_assertions.sv
`timescale 1ns/1ps
module mgmt_chk_assertions (
  // Clock
  input wire logic clk,
  input wire logic rst_n,
  // Link and registers
  input wire logic mdc,
  input wire logic mdio_out,
  input wire logic mdio_oe,
  input wire logic [15:0] control_out,
  input wire logic [15:0] config_one_out
);
  logic [12:0] hi_r;
  always_ff @(posedge clk) begin
    if (!rst_n || !mdio_oe) hi_r <= '0;
    else hi_r <= hi_r + 13'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_zero; !mdio_out [*8]; endsequence
  sequence s_quiet; !mdio_oe [*8]; endsequence
  property p_rise; $rose(mdio_oe) |-> mdc; endproperty
  a_rise: assert property (p_rise) else $error("oe rise");
  property p_ta; $rose(mdio_oe) |-> s_zero; endproperty
  a_ta: assert property (p_ta) else $error("ta bit");
  property p_fell; $fell(mdio_oe) |-> mdc; endproperty
  a_fell: assert property (p_fell) else $error("oe fall");
  property p_len; $fell(mdio_oe) |-> hi_r inside {[13'd675:13'd685], [13'd7075:13'd7085]}; endproperty
  a_len: assert property (p_len) else $error("drive length");
  property p_bit; mdio_oe && $changed(mdio_out) |-> mdc; endproperty
  a_bit: assert property (p_bit) else $error("bit edge");
  property p_cfg; $changed(config_one_out) |-> mdc; endproperty
  a_cfg: assert property (p_cfg) else $error("cfg write");
  property p_ctl; !mdc |-> $stable(control_out); endproperty
  a_ctl: assert property (p_ctl) else $error("ctl write");
  property p_idle; $rose(rst_n) |-> s_quiet; endproperty
  a_idle: assert property (p_idle) else $error("early drive");
endmodule

//--- tb/mgmt_sta.sv
`timescale 1ns/1ps
module mgmt_sta (
  // Link
  output logic mdc,
  output logic sta_oe,
  output logic sta_out,
  input wire logic mdio
);
  initial {mdc, sta_oe, sta_out} = 3'b001;
  // Clock stands low between frames
  task automatic bx(input logic d, input logic v, output logic s);
    mdc = 1'b0;
    sta_oe = d;
    sta_out = v;
    #80;
    mdc = 1'b1;
    s = mdio;
    #80;
  endtask
  task automatic frame(input int pre, input logic rd, input logic [9:0] ad, input int n,
    input logic [15:0] wd, output logic [175:0] q);
    logic [13:0] h;
    logic s;
    h = {2'b01, rd, ~rd, ad};
    repeat (pre) bx(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) bx(1'b1, h[i], s);
    bx(~rd, 1'b1, s);
    bx(~rd, 1'b0, s);
    for (int i = n - 1; i >= 0; i--) begin
      bx(~rd, wd[i % 16], s);
      q[i] = s;
    end
    mdc = 1'b0;
    sta_oe = 1'b0;
    // Idle half bit so the next frame starts in a fresh time step
    #80;
  endtask
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam logic [15:0] IDH = 16'h2a6c; // Arbitrary value
  localparam logic [15:0] IDL = 16'h9d41; // Arbitrary value
  logic clk = 1'b0, rst_n = 1'b0, mdc, sta_oe, sta_out, mdio_out, mdio_oe;
  logic [4:0] phy_select_field = 5'h05;
  logic [15:0] status_in = 16'ha5c3, partner_in = 16'h3c5a, event_in = 16'h0f0f;
  logic [15:0] control_out, config_one_out, config_two_out, mask_out;
  logic [175:0] q;
  int fail_count = 0, samples_checked = 0;
  // Pull-up on the line; a clash reads as unknown
  wire mdio = mdio_oe ? (sta_oe ? 1'bx : mdio_out) : (sta_oe ? sta_out : 1'b1);
  always #2 clk = ~clk;
  phy_mgmt_serial_frame #(.ID_HIGH(IDH), .ID_LOW(IDL)) phy_mgmt_serial_frame_i (.clk, .rst_n, .mdc,
    .mdio_in(mdio), .mdio_out, .mdio_oe, .phy_select_field, .status_in, .partner_in, .event_in,
    .control_out, .config_one_out, .config_two_out, .mask_out);
  mgmt_sta mgmt_sta_i (.mdc, .sta_oe, .sta_out, .mdio);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic acc(input int pre, input logic rd, input logic [9:0] ad, input logic [15:0] wd);
    mgmt_sta_i.frame(pre, rd, ad, 16, wd, q);
  endtask
  task automatic t_rw;
    acc(32, 1'b0, 10'h0b0, 16'hbeef);
    chk(config_one_out, 16'hbeef);
    acc(32, 1'b1, 10'h0b0, 16'h0);
    chk(q[15:0], 16'hbeef);
    acc(32, 1'b1, 10'h0a1, 16'h0);
    chk(q[15:0], status_in);
    acc(32, 1'b0, 10'h0a0, 16'h2100);
    chk(control_out, 16'h2100);
    acc(32, 1'b0, 10'h0b3, 16'h00c3);
    chk(mask_out, 16'h00c3);
  endtask
  task automatic t_refuse;
    acc(32, 1'b0, 10'h0d0, 16'h1234);
    chk(config_one_out, 16'hbeef);
    acc(32, 1'b1, 10'h0d0, 16'h0);
    chk(q[15:0], 16'hffff);
    acc(20, 1'b0, 10'h0b0, 16'h1234);
    chk(config_one_out, 16'hbeef);
  endtask
  task automatic t_burst;
    logic [175:0] e;
    acc(32, 1'b0, 10'h0b1, 16'h0008);
    chk(config_two_out, 16'h0008);
    mgmt_sta_i.frame(32, 1'b1, 10'h0bf, 176, 16'h0, q);
    e = {16'h2100, status_in, IDH, IDL, 16'h01e1, partner_in, 16'hbeef, 16'h0008, event_in, 16'h00c3, 16'h0};
    for (int k = 0; k < 11; k++) chk(q[16*k +: 16], e[16*k +: 16]);
    mgmt_sta_i.frame(32, 1'b0, 10'h0bf, 176, 16'h5a5a, q);
    chk(control_out, 16'h5a5a);
    chk(config_one_out, 16'h5a5a);
    chk(mask_out, 16'h5a5a);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    t_rw;
    t_refuse;
    t_burst;
    tally_and_finish;
  end
  // Frames take about 163 us; allow close to twice that
  initial begin
    #300000;
    fail_count++;
    tally_and_finish;
  end
endmodule
bind phy_mgmt_serial_frame mgmt_chk_assertions mgmt_chk_assertions_i (.clk, .rst_n, .mdc, .mdio_out, .mdio_oe,
  .control_out, .config_one_out);
